// ==== hdl/sdg_pkg.sv ====
// Constants and carrier types for the three-channel step/direction generator.
// Assumes a single 40 MHz clock and the numbered register port of the device.
package sdg_pkg;

    // Register numbers as printed, used directly as the register index
    localparam logic [5:0] REG_RATE_BASE = 6'h12;
    localparam logic [5:0] REG_COUNT_BASE = 6'h15;
    localparam logic [5:0] REG_BUDGET_BASE = 6'h18;
    localparam logic [5:0] REG_COMPARE_BASE = 6'h1B;
    localparam logic [5:0] REG_NEXT_RATE_BASE = 6'h1E;
    localparam logic [5:0] REG_PULSE_WIDTH = 6'h21;
    localparam logic [5:0] REG_DIR_DELAY = 6'h22;
    localparam logic [5:0] REG_CONFIG = 6'h23;

    // Configuration field positions within one channel's byte
    localparam int CFG_CH_STRIDE = 8;
    localparam int CFG_ENABLE = 0;
    localparam int CFG_CONTINUOUS = 1;
    localparam int CFG_STEP_POL = 2;
    localparam int CFG_DIR_POL = 3;
    localparam int CFG_COUNT_CLEAR = 4;
    localparam int CFG_RELOAD_EN = 6;
    localparam int CFG_WIDTH = 24;

    // Shared 48-bit registers hold one 16-bit field per channel
    localparam int FIELD_WIDTH = 16;

    // Reset values
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [15:0] RESET_FIELD = 16'h0000;
    localparam logic [23:0] RESET_CONFIG = 24'h00_0000;

    // Timing: pulse and delay fields count cycles of a 25 MHz base rate
    localparam logic [15:0] CLK_KHZ = 16'(40000);
    localparam logic [15:0] BASE_KHZ = 16'(25000);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] idx;
        logic [47:0] data;
    } sdg_reg_req_s;

    typedef struct packed {
        logic [2:0] step;
        logic [2:0] step_inv;
        logic [2:0] dir;
        logic [2:0] dir_inv;
    } sdg_pins_s;

endpackage : sdg_pkg

// ==== hdl/sdg_step_dir_gen.sv ====
// Three-channel step and direction pulse generator with its register file.
// Assumes register accesses arrive as one-cycle strobes on the same clock.
//
// Behaviour
// - Each channel holds a 32-bit pulse budget and, outside continuous mode, emits no step while it is zero.
// - A budget written at any time replaces the running count at once.
// - Reading the budget returns the pulses still to be made, one less per pulse.
// - The budget is a travel distance in steps, kept apart for each channel.
// - Each channel compares a signed 32-bit value with its signed step count.
// - On equality with reload enabled, the next rate is loaded as active rate.
// - Each channel has a 32-bit next-rate register copied on its compare event.
// - Step pulse width is a 16-bit count of 25 MHz cycles per channel field.
// - Direction-to-step delay is a 16-bit count of 25 MHz cycles per channel.
// - After a direction change the first step waits for the programmed delay.
// - The rate sign sets the direction outputs and its magnitude the interval.
// - A signed 32-bit step count moves by one per step in the current direction.
// - A mode bit selects budget-limited pulses or continuous pulses.
// - Compare reload is enabled by config bits 6, 14 and 22 per channel.
`timescale 1ns/100ps
module sdg_step_dir_gen
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire sdg_pkg::sdg_reg_req_s reg_req_in,
    output logic [47:0] reg_rdata_out,
    output sdg_pkg::sdg_pins_s pins_out
);

    // Register index falls in a three-entry channel group
    function automatic logic group_hit(input logic [5:0] idx,
                                       input logic [5:0] base,
                                       input int ch);
        group_hit = (idx == 6'(base + 6'(ch)));
    endfunction : group_hit

    // One channel's 16-bit field of a shared 48-bit register
    function automatic logic [15:0] field_of(input logic [47:0] word,
                                             input int ch);
        field_of = word[ch * sdg_pkg::FIELD_WIDTH +: sdg_pkg::FIELD_WIDTH];
    endfunction : field_of

    logic [15:0] base_acc;
    logic [23:0] config_reg;
    logic [47:0] width_reg;
    logic [47:0] delay_reg;
    wire [16:0] base_sum = {1'b0, base_acc} + {1'b0, sdg_pkg::BASE_KHZ};
    wire base_tick = (base_sum >= {1'b0, sdg_pkg::CLK_KHZ});
    wire [15:0] next_base_acc = base_tick ?
        16'(base_sum - {1'b0, sdg_pkg::CLK_KHZ}) : base_sum[15:0];
    wire wr_cfg = reg_req_in.wr && (reg_req_in.idx == sdg_pkg::REG_CONFIG);
    wire wr_width = reg_req_in.wr &&
        (reg_req_in.idx == sdg_pkg::REG_PULSE_WIDTH);
    wire wr_delay = reg_req_in.wr &&
        (reg_req_in.idx == sdg_pkg::REG_DIR_DELAY);
    wire [2:0][31:0] budget_view;
    wire [2:0][31:0] count_view;

    // Fractional divider: a 25 MHz tick from the 40 MHz clock
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            base_acc <= 16'h0000;
        else
            base_acc <= next_base_acc;
    end

    // Shared configuration and timing registers
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            config_reg <= sdg_pkg::RESET_CONFIG;
            width_reg <= {3{sdg_pkg::RESET_FIELD}};
            delay_reg <= {3{sdg_pkg::RESET_FIELD}};
        end
        else
        begin
            if (wr_cfg)
                config_reg <= reg_req_in.data[sdg_pkg::CFG_WIDTH-1:0];
            if (wr_width)
                width_reg <= reg_req_in.data;
            if (wr_delay)
                delay_reg <= reg_req_in.data;
        end
    end

    for (genvar c = 0; c < 3; c++)
    begin : g_ch
        localparam int CB = c * sdg_pkg::CFG_CH_STRIDE;
        logic [31:0] rate;
        logic [31:0] next_rate;
        logic [31:0] compare;
        logic [31:0] budget;
        logic [31:0] count;
        logic [31:0] phase;
        logic [15:0] pulse_cnt;
        logic [15:0] delay_cnt;
        logic dir_last;
        logic match_q;
        logic step_q;
        logic dir_q;

        // Register decode for this channel
        wire wr_rate = reg_req_in.wr &&
            group_hit(reg_req_in.idx, sdg_pkg::REG_RATE_BASE, c);
        wire wr_budget = reg_req_in.wr &&
            group_hit(reg_req_in.idx, sdg_pkg::REG_BUDGET_BASE, c);
        wire wr_compare = reg_req_in.wr &&
            group_hit(reg_req_in.idx, sdg_pkg::REG_COMPARE_BASE, c);
        wire wr_next = reg_req_in.wr &&
            group_hit(reg_req_in.idx, sdg_pkg::REG_NEXT_RATE_BASE, c);

        // Configuration bits for this channel
        wire en = config_reg[CB + sdg_pkg::CFG_ENABLE];
        wire continuous = config_reg[CB + sdg_pkg::CFG_CONTINUOUS];
        wire step_pol = config_reg[CB + sdg_pkg::CFG_STEP_POL];
        wire dir_pol = config_reg[CB + sdg_pkg::CFG_DIR_POL];
        wire count_clr = config_reg[CB + sdg_pkg::CFG_COUNT_CLEAR];
        wire reload_en = config_reg[CB + sdg_pkg::CFG_RELOAD_EN];

        // Sign gives direction, magnitude feeds the accumulator
        wire dir_now = rate[31];
        wire [31:0] magnitude = dir_now ? 32'(-rate) : rate;
        wire [32:0] phase_sum = {1'b0, phase} + {1'b0, magnitude};
        wire overflow = base_tick && phase_sum[32];
        wire dir_change = (dir_now != dir_last);
        wire budget_ok = continuous || (budget != 32'h0000_0000);
        // An overflow during a pulse or the direction hold is dropped;
        // software keeps the rate slow enough for this not to matter.
        wire fire = overflow && en && budget_ok && !dir_change &&
            (pulse_cnt == 16'h0000) && (delay_cnt == 16'h0000);
        wire match = (count == compare);
        wire reload = match && !match_q && reload_en;
        wire [31:0] next_count = dir_now ? 32'(count - 32'h1) :
            32'(count + 32'h1);

        // Rate, compare and preload registers
        always_ff @(posedge clk_in or negedge rst_b_in)
        begin
            if (!rst_b_in)
            begin
                rate <= sdg_pkg::RESET_WORD;
                next_rate <= sdg_pkg::RESET_WORD;
                compare <= sdg_pkg::RESET_WORD;
                match_q <= 1'b0;
            end
            else
            begin
                match_q <= match;
                if (wr_rate)
                    rate <= reg_req_in.data[31:0];
                else if (reload)
                    rate <= next_rate;
                if (wr_next)
                    next_rate <= reg_req_in.data[31:0];
                if (wr_compare)
                    compare <= reg_req_in.data[31:0];
            end
        end

        // Budget and position; a software write wins over a pulse
        always_ff @(posedge clk_in or negedge rst_b_in)
        begin
            if (!rst_b_in)
            begin
                budget <= sdg_pkg::RESET_WORD;
                count <= sdg_pkg::RESET_WORD;
            end
            else
            begin
                if (wr_budget)
                    budget <= reg_req_in.data[31:0];
                else if (fire && budget != 32'h0000_0000)
                    budget <= 32'(budget - 32'h1);
                if (count_clr)
                    count <= sdg_pkg::RESET_WORD;
                else if (fire)
                    count <= next_count;
            end
        end

        // Phase accumulator, pulse width and direction hold counters
        always_ff @(posedge clk_in or negedge rst_b_in)
        begin
            if (!rst_b_in)
            begin
                phase <= sdg_pkg::RESET_WORD;
                pulse_cnt <= sdg_pkg::RESET_FIELD;
                delay_cnt <= sdg_pkg::RESET_FIELD;
                dir_last <= 1'b0;
            end
            else
            begin
                dir_last <= dir_now;
                if (!en)
                    phase <= sdg_pkg::RESET_WORD;
                else if (base_tick)
                    phase <= phase_sum[31:0];
                if (fire)
                    pulse_cnt <= field_of(width_reg, c);
                else if (base_tick && pulse_cnt != 16'h0000)
                    pulse_cnt <= 16'(pulse_cnt - 16'h1);
                if (dir_change)
                    delay_cnt <= field_of(delay_reg, c);
                else if (base_tick && delay_cnt != 16'h0000)
                    delay_cnt <= 16'(delay_cnt - 16'h1);
            end
        end

        // Registered pin levels with programmable polarity
        always_ff @(posedge clk_in or negedge rst_b_in)
        begin
            if (!rst_b_in)
            begin
                step_q <= 1'b0;
                dir_q <= 1'b0;
            end
            else
            begin
                step_q <= (pulse_cnt != 16'h0000) ^ step_pol;
                dir_q <= dir_now ^ dir_pol;
            end
        end

        assign pins_out.step[c] = step_q;
        assign pins_out.step_inv[c] = ~step_q;
        assign pins_out.dir[c] = dir_q;
        assign pins_out.dir_inv[c] = ~dir_q;
        assign budget_view[c] = budget;
        assign count_view[c] = count;
    end

    // Read selection; write-only and unmapped registers read as zero
    wire [1:0] rd_ch_count = 2'(reg_req_in.idx - sdg_pkg::REG_COUNT_BASE);
    wire [1:0] rd_ch_budget = 2'(reg_req_in.idx - sdg_pkg::REG_BUDGET_BASE);
    wire rd_is_count = (reg_req_in.idx >= sdg_pkg::REG_COUNT_BASE) &&
        (reg_req_in.idx < sdg_pkg::REG_BUDGET_BASE);
    wire rd_is_budget = (reg_req_in.idx >= sdg_pkg::REG_BUDGET_BASE) &&
        (reg_req_in.idx < sdg_pkg::REG_COMPARE_BASE);
    wire [47:0] rd_mux = rd_is_count ? {16'h0000, count_view[rd_ch_count]} :
        rd_is_budget ? {16'h0000, budget_view[rd_ch_budget]} : 48'h0;

    // Read data is captured on the strobe and held until the next read
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            reg_rdata_out <= 48'h0000_0000_0000;
        else if (reg_req_in.rd)
            reg_rdata_out <= rd_mux;
    end

endmodule : sdg_step_dir_gen

// ==== testbench/sdg_props.sv ====
// Checker for the register port and pins of the step/direction generator.
// Assumes it is bound to sdg_step_dir_gen and sees only its ports.
`timescale 1ns/100ps
module sdg_props
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire sdg_pkg::sdg_reg_req_s reg_req_in,
    input wire logic [47:0] reg_rdata_out,
    input wire sdg_pkg::sdg_pins_s pins_out
);
    logic armed;
    logic arm_wr;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // Pins may only leave idle once a rate or config write has landed
    assign arm_wr = reg_req_in.wr && (reg_req_in.idx == 6'h23 ||
        (reg_req_in.idx >= 6'h12 && reg_req_in.idx <= 6'h14));
    always_ff @(posedge clk_in or negedge rst_b_in)
        if (!rst_b_in)
            armed <= 1'b0;
        else if (arm_wr)
            armed <= 1'b1;
    sequence s_rd(logic [5:0] i);
        reg_req_in.rd && reg_req_in.idx == i;
    endsequence
    chk_step_inv_pair: assert property (pins_out.step_inv == ~pins_out.step)
        else $error("step pair not complementary");
    chk_dir_inv_pair: assert property (pins_out.dir_inv == ~pins_out.dir)
        else $error("dir pair not complementary");
    chk_rdata_hold: assert property (!reg_req_in.rd |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    chk_cmp_rd_zero: assert property (s_rd(6'h1B) |=> reg_rdata_out == '0)
        else $error("compare register readable");
    chk_rate_rd_zero: assert property (s_rd(6'h12) |=> reg_rdata_out == '0)
        else $error("rate register readable");
    chk_next_rd_zero: assert property (s_rd(6'h1E) |=> reg_rdata_out == '0)
        else $error("next rate register readable");
    chk_width_rd_zero: assert property (s_rd(6'h21) |=> reg_rdata_out == '0)
        else $error("pulse width register readable");
    chk_budget_rd_high: assert property (s_rd(6'h18) |=> reg_rdata_out[47:32] == 16'h0000)
        else $error("budget read upper bits set");
    chk_idle_step_low: assert property (!armed |-> pins_out.step == 3'h0)
        else $error("step left idle before setup");
    chk_idle_dir_low: assert property (!armed |-> pins_out.dir == 3'h0)
        else $error("dir left idle before setup");
endmodule : sdg_props

// ==== testbench/sdg_motor_model.sv ====
// Motor driver model: counts steps per channel, times channel 0 pulses.
// Assumes default polarities, so step active high and dir 1 means reverse.
`timescale 1ns/100ps
module sdg_motor_model
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [2:0] step_in,
    input wire logic [2:0] dir_in,
    output logic [2:0][31:0] pos_out,
    output logic [15:0] hi_out,
    output logic [15:0] gap_out
);
    logic [2:0] step_q;
    logic dir_q;
    logic fresh;
    logic [15:0] hi_cnt;
    logic [15:0] since_dir;
    // Dir is sampled at the step edge, as a real driver would do
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pos_out <= '0;
            step_q <= '0;
            {dir_q, fresh, hi_cnt, since_dir, hi_out, gap_out} <= '0;
        end
        else
        begin
            step_q <= step_in;
            dir_q <= dir_in[0];
            for (int c = 0; c < 3; c++)
                if (step_in[c] && !step_q[c])
                    pos_out[c] <= dir_in[c] ? pos_out[c] - 1 : pos_out[c] + 1;
            hi_cnt <= step_in[0] ? hi_cnt + 16'h0001 : 16'h0000;
            if (!step_in[0] && step_q[0])
                hi_out <= hi_cnt;
            since_dir <= (dir_in[0] != dir_q) ? 16'h0000 : since_dir + 16'h0001;
            if (dir_in[0] != dir_q)
                fresh <= 1'b1;
            else if (step_in[0] && !step_q[0] && fresh)
            begin
                gap_out <= since_dir;
                fresh <= 1'b0;
            end
        end
    end
endmodule : sdg_motor_model

// ==== testbench/tb.sv ====
// Self-checking bench: register tasks drive the port, the model counts steps.
// Assumes the design package and the checker are compiled first.
`timescale 1ns/100ps
`define CHK(a, e) \
    begin \
        check_count++; \
        if ((a) !== (e)) \
        begin \
            n_errors++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); \
        end \
    end
module tb;
    logic clk_in;
    logic rst_b_in;
    sdg_pkg::sdg_reg_req_s req;
    logic [47:0] rdata;
    sdg_pkg::sdg_pins_s pins;
    logic [2:0][31:0] pos;
    logic [15:0] hi;
    logic [15:0] gap;
    int n_errors = 0;
    int check_count = 0;
    logic [5:0] zl [11] = '{6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A,
        6'h12, 6'h1B, 6'h1E, 6'h21, 6'h3F};
    sdg_step_dir_gen u_sdg_step_dir_gen (.clk_in(clk_in),
        .rst_b_in(rst_b_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .pins_out(pins));
    sdg_motor_model u_sdg_motor_model (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .step_in(pins.step), .dir_in(pins.dir), .pos_out(pos), .hi_out(hi),
        .gap_out(gap));
    // One-cycle strobes, launched just after an edge
    task automatic wr(input logic [5:0] i, input logic [47:0] d);
        @(posedge clk_in);
        req <= '{wr: 1'b1, rd: 1'b0, idx: i, data: d};
        @(posedge clk_in);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [5:0] i, input logic [47:0] e);
        @(posedge clk_in);
        req <= '{wr: 1'b0, rd: 1'b1, idx: i, data: 48'h0};
        @(posedge clk_in);
        req.rd <= 1'b0;
        @(negedge clk_in);
        `CHK(rdata, e)
    endtask : rdc
    // Bounded wait; a miss shows up in the following compare
    task automatic wait_pos(input int c, input logic [31:0] v);
        int k;
        k = 0;
        while (pos[c] !== v && k < 3000)
        begin
            @(negedge clk_in);
            k++;
        end
        repeat (200) @(negedge clk_in);
    endtask : wait_pos
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // Run should need well under 10k cycles
    initial
    begin
        #(25 * 40000);
        n_errors++;
        stop_test();
    end
    initial
    begin
        req = '0;
        rst_b_in = 1'b0;
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        foreach (zl[i]) rdc(zl[i], 48'h0);
        $display("test reset_values done");
        wr(6'h21, 48'h0002_0002_0002);
        wr(6'h12, 48'h2000_0000);
        wr(6'h18, 48'h5);
        wr(6'h23, 48'h1);
        wait_pos(0, 32'h5);
        `CHK(pos[0], 32'h5)
        `CHK(hi inside {[2:4]}, 1'b1)
        rdc(6'h18, 48'h0);
        wr(6'h15, 48'h77);
        rdc(6'h15, 48'h5);
        $display("test budget_run done");
        wr(6'h18, 48'hA);
        // Rewrite while stepping; the watchdog bounds this wait
        while (pos[0] !== 32'h8)
            @(negedge clk_in);
        wr(6'h18, 48'h2);
        wait_pos(0, 32'hA);
        `CHK(pos[0], 32'hA)
        $display("test budget_rewrite done");
        wr(6'h22, 48'h14);
        // Reverse before granting steps, so none leaks out forward
        wr(6'h12, 48'hE000_0000);
        wr(6'h18, 48'h3);
        wait_pos(0, 32'h7);
        `CHK(pos[0], 32'h7)
        `CHK(pins.dir[0], 1'b1)
        `CHK(gap >= 16'h001E, 1'b1)
        rdc(6'h15, 48'h7);
        $display("test reversal done");
        wr(6'h13, 48'h2000_0000);
        wr(6'h23, 48'h301);
        wait_pos(1, 32'h4);
        `CHK(pos[1] >= 32'h4, 1'b1)
        rdc(6'h19, 48'h0);
        $display("test continuous done");
        wr(6'h1D, 48'h2);
        wr(6'h20, 48'h0);
        wr(6'h14, 48'h2000_0000);
        wr(6'h23, 48'h43_0301);
        wait_pos(2, 32'h2);
        `CHK(pos[2], 32'h2)
        rdc(6'h17, 48'h2);
        wr(6'h23, 48'h53_0301);
        rdc(6'h17, 48'h0);
        $display("test compare_reload done");
        stop_test();
    end
endmodule : tb
bind sdg_step_dir_gen sdg_props u_sdg_props (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .pins_out(pins_out));
